// ===== eqc_pkg.sv
// Shared constants and decode functions for the equalizer control logic
package eqc_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register offsets (SMBus command byte)
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] CH0_BOOST_OFS = 8'h03;
   localparam logic [7:0] CH12_BOOST_OFS = 8'h04;
   localparam logic [7:0] RISE_THR_OFS = 8'h05;
   localparam logic [7:0] FALL_THR_OFS = 8'h06;
   localparam logic [7:0] EN_SRC_OFS = 8'h07;
   localparam logic [7:0] OUT_LVL_OFS = 8'h08;

   // Reset values
   localparam logic [7:0] CH0_BOOST_RST = 8'h77;
   localparam logic [7:0] CH12_BOOST_RST = 8'h77;
   localparam logic [7:0] RISE_THR_RST = 8'h00;
   localparam logic [7:0] FALL_THR_RST = 8'h00;
   localparam logic [7:0] EN_SRC_RST = 8'h00;
   localparam logic [7:0] OUT_LVL_RST = 8'h78;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   // Field positions
   localparam int STATUS_DET_BIT = 0;
   localparam int EN_SRC_BIT = 0;
   localparam int DEV_EN_BIT = 3;
   localparam int CH_EN_HI_BIT = 7;
   localparam int BOOST_HI_LSB = 4;
   localparam int BOOST_LO_LSB = 0;
   localparam int THR_LSB = 0;
   localparam int OUT_LVL_LSB = 2;
   localparam int BOOST_W = 3;
   localparam int THR_W = 2;
   localparam int LVL_W = 2;
   localparam int AMP_W = 12;

   // Default 7-bit SMBus slave address, arbitrary value
   localparam logic [6:0] SMB_ADDR_DEF = 7'h2C;

   ////////////////////////////////////////////////////////////////////////
   // Upper (turn-on) threshold in mV from its 2-bit code
   function automatic logic [AMP_W-1:0] upper_mv(input logic [1:0] code);
      case (code)
         2'h0: upper_mv = 12'h046;
         2'h1: upper_mv = 12'h037;
         2'h2: upper_mv = 12'h05A;
         default: upper_mv = 12'h04B;
      endcase
   endfunction : upper_mv

   // Lower (turn-off) threshold in mV from its 2-bit code
   function automatic logic [AMP_W-1:0] lower_mv(input logic [1:0] code);
      case (code)
         2'h0: lower_mv = 12'h028;
         2'h1: lower_mv = 12'h01E;
         2'h2: lower_mv = 12'h037;
         default: lower_mv = 12'h02D;
      endcase
   endfunction : lower_mv

endpackage : eqc_pkg

// ===== eqc_reg_if.sv
// Register access carrier between the SMBus engine and the register file
`timescale 1ns/1ps
interface eqc_reg_if;
   logic wr_stb;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport engine (output wr_stb, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input addr, input wdata, output rdata);
endinterface : eqc_reg_if

// ===== eqc_regs.sv
// Register file of the equalizer control logic
`timescale 1ns/1ps
module eqc_regs
(
   input wire logic clk,
   input wire logic nrst,
   eqc_reg_if.regs bus,
   input wire logic detect_flag,
   output logic [7:0] ch0_boost,
   output logic [7:0] ch12_boost,
   output logic [7:0] rise_thr,
   output logic [7:0] fall_thr,
   output logic [7:0] en_src,
   output logic [7:0] out_lvl
);
   logic [7:0] ch0_r, ch0_nxt, ch12_r, ch12_nxt, rise_r, rise_nxt;
   logic [7:0] fall_r, fall_nxt, src_r, src_nxt, lvl_r, lvl_nxt;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      ch0_nxt = ch0_r;
      ch12_nxt = ch12_r;
      rise_nxt = rise_r;
      fall_nxt = fall_r;
      src_nxt = src_r;
      lvl_nxt = lvl_r;
      if (bus.wr_stb)
      begin
         case (bus.addr)
            eqc_pkg::CH0_BOOST_OFS: ch0_nxt = bus.wdata;
            eqc_pkg::CH12_BOOST_OFS: ch12_nxt = bus.wdata;
            eqc_pkg::RISE_THR_OFS: rise_nxt = bus.wdata;
            eqc_pkg::FALL_THR_OFS: fall_nxt = bus.wdata;
            eqc_pkg::EN_SRC_OFS: src_nxt = bus.wdata;
            eqc_pkg::OUT_LVL_OFS: lvl_nxt = bus.wdata;
            default: ch0_nxt = ch0_r;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         ch0_r <= eqc_pkg::CH0_BOOST_RST;
         ch12_r <= eqc_pkg::CH12_BOOST_RST;
         rise_r <= eqc_pkg::RISE_THR_RST;
         fall_r <= eqc_pkg::FALL_THR_RST;
         src_r <= eqc_pkg::EN_SRC_RST;
         lvl_r <= eqc_pkg::OUT_LVL_RST;
      end
      else
      begin
         ch0_r <= ch0_nxt;
         ch12_r <= ch12_nxt;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
         src_r <= src_nxt;
         lvl_r <= lvl_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status is live; unmapped offsets read as zero
   always_comb
   begin
      case (bus.addr)
         eqc_pkg::STATUS_OFS: bus.rdata = {7'h00, detect_flag};
         eqc_pkg::CH0_BOOST_OFS: bus.rdata = ch0_r;
         eqc_pkg::CH12_BOOST_OFS: bus.rdata = ch12_r;
         eqc_pkg::RISE_THR_OFS: bus.rdata = rise_r;
         eqc_pkg::FALL_THR_OFS: bus.rdata = fall_r;
         eqc_pkg::EN_SRC_OFS: bus.rdata = src_r;
         eqc_pkg::OUT_LVL_OFS: bus.rdata = lvl_r;
         default: bus.rdata = eqc_pkg::UNMAPPED_RD;
      endcase
   end

   assign ch0_boost = ch0_r;
   assign ch12_boost = ch12_r;
   assign rise_thr = rise_r;
   assign fall_thr = fall_r;
   assign en_src = src_r;
   assign out_lvl = lvl_r;
endmodule : eqc_regs

// ===== eqc_sig_detect.sv
// Clock-channel signal detect with hysteresis between two thresholds
`timescale 1ns/1ps
module eqc_sig_detect
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [eqc_pkg::AMP_W-1:0] clk_amp_mv,
   input wire logic [1:0] upper_code,
   input wire logic [1:0] lower_code,
   output logic signal_detect_flag
);
   logic det_r, det_nxt;

   ////////////////////////////////////////////////////////////////////////
   // Runs in standby too, so automatic enable can wake the device
   always_comb
   begin
      det_nxt = det_r;
      if (clk_amp_mv > eqc_pkg::upper_mv(upper_code))
         det_nxt = 1'b1;
      else if (clk_amp_mv < eqc_pkg::lower_mv(lower_code))
         det_nxt = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         det_r <= 1'b0;
      else
         det_r <= det_nxt;
   end

   assign signal_detect_flag = det_r;
endmodule : eqc_sig_detect

// ===== eqc_top.sv
// Equalizer control logic: SMBus slave, boost and enable selection
`timescale 1ns/1ps
module eqc_top
#(
   parameter logic [6:0] SMB_ADDR = eqc_pkg::SMB_ADDR_DEF
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n,
   input wire logic boost_source_pin,
   input wire logic [eqc_pkg::BOOST_W-1:0] boost_select_pins,
   input wire logic enable_pin,
   input wire logic [eqc_pkg::AMP_W-1:0] clk_amp_mv,
   output logic signal_detect_pin,
   output logic [eqc_pkg::BOOST_W-1:0] ch0_boost_code,
   output logic [eqc_pkg::BOOST_W-1:0] ch1_boost_code,
   output logic [eqc_pkg::BOOST_W-1:0] ch2_boost_code,
   output logic [2:0] data_ch_en,
   output logic clk_ch_en,
   output logic dev_active,
   output logic [eqc_pkg::LVL_W-1:0] out_level_code,
   output logic [eqc_pkg::THR_W-1:0] detect_upper_threshold,
   output logic [eqc_pkg::THR_W-1:0] detect_lower_threshold
);
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_ADDR = 5'h02,
      ST_CMD = 5'h04,
      ST_WDAT = 5'h08,
      ST_RDAT = 5'h10
   } eqc_state_t;

   eqc_reg_if rif ();

   eqc_state_t state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] shift_r, shift_nxt;
   logic [7:0] ptr_r, ptr_nxt;
   logic drive_r, drive_nxt;
   logic scl_q_r, sda_q_r;
   logic wr_r, wr_nxt;
   logic [7:0] wdat_r, wdat_nxt;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic signal_detect_flag;
   logic [7:0] ch0_reg, ch12_reg, rise_reg, fall_reg, src_reg, lvl_reg;

   ////////////////////////////////////////////////////////////////////////
   // Submodules
   eqc_regs u_regs
   (
      .clk(clk),
      .nrst(nrst),
      .bus(rif.regs),
      .detect_flag(signal_detect_flag),
      .ch0_boost(ch0_reg),
      .ch12_boost(ch12_reg),
      .rise_thr(rise_reg),
      .fall_thr(fall_reg),
      .en_src(src_reg),
      .out_lvl(lvl_reg)
   );

   eqc_sig_detect u_det
   (
      .clk(clk),
      .nrst(nrst),
      .clk_amp_mv(clk_amp_mv),
      .upper_code(rise_reg[eqc_pkg::THR_LSB +: eqc_pkg::THR_W]),
      .lower_code(fall_reg[eqc_pkg::THR_LSB +: eqc_pkg::THR_W]),
      .signal_detect_flag(signal_detect_flag)
   );

   // Pin drives the same flop value the status register reads
   assign signal_detect_pin = signal_detect_flag;

   assign rif.wr_stb = wr_r;
   assign rif.addr = ptr_r;
   assign rif.wdata = wdat_r;

   ////////////////////////////////////////////////////////////////////////
   // SMBus line events, from the previous sample of each line
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end
      else
      begin
         scl_q_r <= scl_i;
         sda_q_r <= sda_i;
      end
   end

   assign scl_rise = scl_i & ~scl_q_r;
   assign scl_fall = ~scl_i & scl_q_r;
   assign start_c = scl_i & scl_q_r & sda_q_r & ~sda_i;
   assign stop_c = scl_i & scl_q_r & ~sda_q_r & sda_i;

   ////////////////////////////////////////////////////////////////////////
   // SMBus byte engine; cnt 0..7 data bits, 8 ack clock, 9 ack release
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      ptr_nxt = ptr_r;
      drive_nxt = drive_r;
      wr_nxt = 1'b0;
      wdat_nxt = wdat_r;
      if (start_c)
      begin
         state_nxt = ST_ADDR;
         cnt_nxt = 4'h0;
         drive_nxt = 1'b0;
      end
      else if (stop_c)
      begin
         state_nxt = ST_IDLE;
         drive_nxt = 1'b0;
      end
      else
      begin
         case (state_r)
            ST_IDLE:
               cnt_nxt = 4'h0;
            ST_ADDR, ST_CMD, ST_WDAT:
            begin
               if (scl_rise && cnt_r < 4'h8)
               begin
                  shift_nxt = {shift_r[6:0], sda_i};
                  cnt_nxt = cnt_r + 4'h1;
               end
               else if (scl_rise && cnt_r == 4'h8)
                  cnt_nxt = 4'h9;
               else if (scl_fall && cnt_r == 4'h8)
               begin
                  drive_nxt = 1'b1;
                  if (state_r == ST_ADDR && shift_r[7:1] != SMB_ADDR)
                  begin
                     // Foreign address: no acknowledge, wait for start
                     drive_nxt = 1'b0;
                     state_nxt = ST_IDLE;
                  end
                  else if (state_r == ST_CMD)
                     ptr_nxt = shift_r;
                  else if (state_r == ST_WDAT)
                  begin
                     wr_nxt = 1'b1;
                     wdat_nxt = shift_r;
                  end
               end
               else if (scl_fall && cnt_r == 4'h9)
               begin
                  cnt_nxt = 4'h0;
                  drive_nxt = 1'b0;
                  if (state_r == ST_ADDR && shift_r[0])
                  begin
                     state_nxt = ST_RDAT;
                     shift_nxt = rif.rdata;
                     drive_nxt = ~rif.rdata[7];
                  end
                  else if (state_r == ST_ADDR)
                     state_nxt = ST_CMD;
                  else
                     state_nxt = ST_WDAT;
               end
            end
            ST_RDAT:
            begin
               if (scl_rise && cnt_r < 4'h8)
                  cnt_nxt = cnt_r + 4'h1;
               else if (scl_fall && cnt_r < 4'h8)
               begin
                  shift_nxt = {shift_r[6:0], 1'b0};
                  drive_nxt = ~shift_r[6];
               end
               else if (scl_fall && cnt_r == 4'h8)
                  drive_nxt = 1'b0;
               else if (scl_rise && cnt_r == 4'h8)
               begin
                  // Master nack ends the read; ack repeats the register
                  if (sda_i)
                     state_nxt = ST_IDLE;
                  else
                  begin
                     cnt_nxt = 4'h9;
                     shift_nxt = rif.rdata;
                  end
               end
               else if (scl_fall && cnt_r == 4'h9)
               begin
                  cnt_nxt = 4'h0;
                  drive_nxt = ~shift_r[7];
               end
            end
            default:
               state_nxt = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         state_r <= ST_IDLE;
         cnt_r <= 4'h0;
         shift_r <= 8'h00;
         ptr_r <= 8'h00;
         drive_r <= 1'b0;
         wr_r <= 1'b0;
         wdat_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         ptr_r <= ptr_nxt;
         drive_r <= drive_nxt;
         wr_r <= wr_nxt;
         wdat_r <= wdat_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Device control outputs, all registered
   logic [eqc_pkg::BOOST_W-1:0] b0_nxt, b1_nxt, b2_nxt;
   logic [eqc_pkg::BOOST_W-1:0] b0_r, b1_r, b2_r;
   logic act_nxt, act_r;
   logic [2:0] den_nxt, den_r;
   logic cen_nxt, cen_r, sda_oe_n_r;
   logic [eqc_pkg::LVL_W-1:0] lvl_r;
   logic [eqc_pkg::THR_W-1:0] up_r, lo_r;

   always_comb
   begin
      // Unconnected pin reads high via the pad pull-up
      if (boost_source_pin)
      begin
         b0_nxt = boost_select_pins;
         b1_nxt = boost_select_pins;
         b2_nxt = boost_select_pins;
      end
      else
      begin
         b0_nxt = ch0_reg[eqc_pkg::BOOST_HI_LSB +: eqc_pkg::BOOST_W];
         b1_nxt = ch12_reg[eqc_pkg::BOOST_LO_LSB +: eqc_pkg::BOOST_W];
         b2_nxt = ch12_reg[eqc_pkg::BOOST_HI_LSB +: eqc_pkg::BOOST_W];
      end
      // Detect pin wired to enable pin gives automatic standby
      if (src_reg[eqc_pkg::EN_SRC_BIT])
         act_nxt = ~ch0_reg[eqc_pkg::DEV_EN_BIT];
      else
         act_nxt = enable_pin;
      // Per-channel disable bits only trim an active device
      den_nxt[0] = act_nxt & ~ch0_reg[eqc_pkg::CH_EN_HI_BIT];
      den_nxt[1] = act_nxt & ~ch12_reg[eqc_pkg::DEV_EN_BIT];
      den_nxt[2] = act_nxt & ~ch12_reg[eqc_pkg::CH_EN_HI_BIT];
      cen_nxt = act_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         b0_r <= 3'h0;
         b1_r <= 3'h0;
         b2_r <= 3'h0;
         act_r <= 1'b0;
         den_r <= 3'h0;
         cen_r <= 1'b0;
         lvl_r <= eqc_pkg::OUT_LVL_RST[eqc_pkg::OUT_LVL_LSB +: eqc_pkg::LVL_W];
         up_r <= eqc_pkg::RISE_THR_RST[eqc_pkg::THR_LSB +: eqc_pkg::THR_W];
         lo_r <= eqc_pkg::FALL_THR_RST[eqc_pkg::THR_LSB +: eqc_pkg::THR_W];
         sda_oe_n_r <= 1'b1;
      end
      else
      begin
         b0_r <= b0_nxt;
         b1_r <= b1_nxt;
         b2_r <= b2_nxt;
         act_r <= act_nxt;
         den_r <= den_nxt;
         cen_r <= cen_nxt;
         lvl_r <= lvl_reg[eqc_pkg::OUT_LVL_LSB +: eqc_pkg::LVL_W];
         up_r <= rise_reg[eqc_pkg::THR_LSB +: eqc_pkg::THR_W];
         lo_r <= fall_reg[eqc_pkg::THR_LSB +: eqc_pkg::THR_W];
         sda_oe_n_r <= ~drive_nxt;
      end
   end

   // Open-drain: only ever pulls low
   assign sda_o = 1'b0;
   assign sda_oe_n = sda_oe_n_r;
   assign ch0_boost_code = b0_r;
   assign ch1_boost_code = b1_r;
   assign ch2_boost_code = b2_r;
   assign dev_active = act_r;
   assign data_ch_en = den_r;
   assign clk_ch_en = cen_r;
   assign out_level_code = lvl_r;
   assign detect_upper_threshold = up_r;
   assign detect_lower_threshold = lo_r;
endmodule : eqc_top

// ===== eqc_top_assertions.sv
// Port-level checks of the equalizer control logic
`timescale 1ns/1ps
module eqc_top_assertions
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic scl_i,
   input wire logic sda_oe_n,
   input wire logic boost_source_pin,
   input wire logic [eqc_pkg::BOOST_W-1:0] boost_select_pins,
   input wire logic [eqc_pkg::AMP_W-1:0] clk_amp_mv,
   input wire logic signal_detect_pin,
   input wire logic [eqc_pkg::BOOST_W-1:0] ch0_boost_code,
   input wire logic [eqc_pkg::BOOST_W-1:0] ch1_boost_code,
   input wire logic [eqc_pkg::BOOST_W-1:0] ch2_boost_code,
   input wire logic [2:0] data_ch_en,
   input wire logic clk_ch_en,
   input wire logic dev_active,
   input wire logic [eqc_pkg::LVL_W-1:0] out_level_code,
   input wire logic [eqc_pkg::THR_W-1:0] detect_upper_threshold
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   // Bus idle long enough that no write can still reach a boost output
   sequence quiet_s;
      (!boost_source_pin && scl_i) [*4];
   endsequence
   sequence reg_src_s;
      quiet_s ##1 !boost_source_pin;
   endsequence
   AST_BOOST_PINS: assert property (
      boost_source_pin |=> ch0_boost_code == $past(boost_select_pins)
      && ch1_boost_code == $past(boost_select_pins)
      && ch2_boost_code == $past(boost_select_pins))
      else $error("pin boost code not on all channels");
   AST_BOOST_REGS: assert property (
      reg_src_s |-> $stable(ch0_boost_code) && $stable(ch1_boost_code)
      && $stable(ch2_boost_code))
      else $error("register boost code moved without a write");
   AST_CLK_FOLLOWS: assert property (
      clk_ch_en == dev_active)
      else $error("clock channel enable differs from state");
   AST_STANDBY_OFF: assert property (
      !dev_active |-> data_ch_en == 3'h0)
      else $error("data channel enabled in standby");
   AST_DETECT_ON: assert property (
      clk_amp_mv > 12'h05A |=> signal_detect_pin)
      else $error("detect flag low above every upper level");
   AST_DETECT_OFF: assert property (
      clk_amp_mv < 12'h01E |=> !signal_detect_pin)
      else $error("detect flag high below every lower level");
   AST_DETECT_ROSE: assert property (
      $rose(signal_detect_pin) |-> $past(clk_amp_mv) > 12'h037)
      else $error("detect flag rose below the upper level");
   AST_DETECT_FELL: assert property (
      $fell(signal_detect_pin) |-> $past(clk_amp_mv) < 12'h037)
      else $error("detect flag fell above the lower level");
   AST_RESET_STATE: assert property (disable iff (1'h0)
      !nrst |=> out_level_code == 2'h2 && !signal_detect_pin
      && !dev_active && sda_oe_n && detect_upper_threshold == 2'h0)
      else $error("wrong state during reset");
endmodule : eqc_top_assertions

bind eqc_top eqc_top_assertions chk_u (.clk(clk), .nrst(nrst),
   .scl_i(scl_i), .sda_oe_n(sda_oe_n), .boost_source_pin(boost_source_pin),
   .boost_select_pins(boost_select_pins), .clk_amp_mv(clk_amp_mv),
   .signal_detect_pin(signal_detect_pin), .ch0_boost_code(ch0_boost_code),
   .ch1_boost_code(ch1_boost_code), .ch2_boost_code(ch2_boost_code),
   .data_ch_en(data_ch_en), .clk_ch_en(clk_ch_en), .dev_active(dev_active),
   .out_level_code(out_level_code),
   .detect_upper_threshold(detect_upper_threshold));

// ===== eqc_smb_host.sv
// Behavioural SMBus host driving the control bus of the block
`timescale 1ns/1ps
module eqc_smb_host
#(
   parameter logic [6:0] DEV_ADDR = 7'h2C
)
(
   input wire logic clk,
   input wire logic sda_w,
   output logic scl,
   output logic sda_m
);
   // Clock stands high between frames; a released data line reads high
   initial
   begin
      scl = 1'h1;
      sda_m = 1'h1;
   end
   ////////////////////////////////////////
   task automatic hc(input int n);
      repeat (n) @(negedge clk);
   endtask : hc
   task automatic start();
      sda_m = 1'h1;
      hc(4);
      scl = 1'h1;
      hc(4);
      sda_m = 1'h0;
      hc(4);
      scl = 1'h0;
   endtask : start
   task automatic stop();
      sda_m = 1'h0;
      hc(4);
      scl = 1'h1;
      hc(4);
      sda_m = 1'h1;
      hc(4);
   endtask : stop
   // Nine clock pulses; the ninth bit is the acknowledge slot
   task automatic bits(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--)
      begin
         sda_m = d[i];
         hc(4);
         scl = 1'h1;
         hc(4);
         q[i] = sda_w;
         scl = 1'h0;
      end
   endtask : bits
   task automatic wr(input logic [6:0] sa, input logic [7:0] a,
      input logic [7:0] d, output logic ack);
      logic [8:0] q0, q1, q2;
      start();
      bits({sa, 1'h0, 1'h1}, q0);
      bits({a, 1'h1}, q1);
      bits({d, 1'h1}, q2);
      stop();
      ack = !q0[0] && !q1[0] && !q2[0];
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [8:0] q;
      start();
      bits({DEV_ADDR, 1'h0, 1'h1}, q);
      bits({a, 1'h1}, q);
      start();
      bits({DEV_ADDR, 1'h1, 1'h1}, q);
      bits(9'h1FF, q);
      stop();
      d = q[8:1];
   endtask : rd
endmodule : eqc_smb_host

// ===== tb.sv
// Self-checking testbench of the equalizer control logic
`timescale 1ns/1ps
module tb;
   localparam logic [6:0] ADDR = 7'h2C; // Arbitrary bus address
   logic clk, nrst, boost_src, en_pin, auto_en, det, dev_act, clk_en;
   logic sda_oe_n, sda_o, scl, sda_m;
   logic [2:0] boost_pins, b0, b1, b2, den;
   logic [1:0] lvl, up_c, lo_c;
   logic [11:0] amp;
   int failures;
   int compares;
   wire sda_w = sda_m & (sda_oe_n | sda_o);
   wire en_w = auto_en ? det : en_pin;
   eqc_top #(.SMB_ADDR(ADDR)) dut_u
   (
      .clk(clk), .nrst(nrst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_n(sda_oe_n), .boost_source_pin(boost_src),
      .boost_select_pins(boost_pins), .enable_pin(en_w), .clk_amp_mv(amp),
      .signal_detect_pin(det), .ch0_boost_code(b0), .ch1_boost_code(b1),
      .ch2_boost_code(b2), .data_ch_en(den), .clk_ch_en(clk_en),
      .dev_active(dev_act), .out_level_code(lvl),
      .detect_upper_threshold(up_c), .detect_lower_threshold(lo_c)
   );
   eqc_smb_host #(.DEV_ADDR(ADDR)) host_u
   (
      .clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m)
   );
   ////////////////////////////////////////
   task automatic print_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic chk(input string what, input logic [11:0] seen,
      input logic [11:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic w(input logic [7:0] a, input logic [7:0] d);
      logic ack;
      host_u.wr(ADDR, a, d, ack);
      chk("ack", 12'(ack), 12'h001);
   endtask : w
   task automatic rchk(input string what, input logic [7:0] a,
      input logic [7:0] exp);
      logic [7:0] q;
      host_u.rd(a, q);
      chk(what, 12'(q), 12'(exp));
   endtask : rchk
   // Bounded wait on the state output; running out ends the run
   task automatic wait_for(input logic v);
      int n = 0;
      while (dev_act !== v && n < 20)
      begin
         tick(1);
         n++;
      end
      if (dev_act !== v)
      begin
         failures++;
         print_verdict();
      end
   endtask : wait_for
   ////////////////////////////////////////
   task automatic s_reset();
      logic [7:0] ofs[8] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
         8'h08, 8'h10};
      logic [7:0] rst[8] = '{8'h00, 8'h77, 8'h77, 8'h00, 8'h00, 8'h00,
         8'h78, 8'h00};
      logic ack;
      chk("level", 12'(lvl), 12'h002);
      for (int i = 0; i < 8; i++)
         rchk("reset value", ofs[i], rst[i]);
      host_u.wr(ADDR ^ 7'h01, 8'h07, 8'h01, ack);
      chk("foreign ack", 12'(ack), 12'h000);
      rchk("foreign write", 8'h07, 8'h00);
      w(8'h00, 8'hFF);
      rchk("status", 8'h00, 8'h00);
   endtask : s_reset
   task automatic s_boost();
      boost_src = 1'h1;
      for (int c = 0; c < 8; c++)
      begin
         boost_pins = c[2:0];
         tick(2);
         chk("pin boost", 12'({b2, b1, b0}), 12'({3{c[2:0]}}));
      end
      w(8'h03, 8'h50);
      w(8'h04, 8'h31);
      boost_src = 1'h0;
      tick(2);
      chk("reg boost", 12'({b2, b1, b0}), 12'h0CD);
      boost_pins = 3'h2;
      tick(2);
      chk("reg boost", 12'({b2, b1, b0}), 12'h0CD);
   endtask : s_boost
   task automatic s_enable();
      // Row bits: source, pin, register bit, expected active
      logic [3:0] row[4] = '{4'h7, 4'h0, 4'h9, 4'hE};
      foreach (row[i])
      begin
         en_pin = row[i][2];
         w(8'h03, {4'h5, row[i][1], 3'h0});
         w(8'h07, {7'h00, row[i][3]});
         tick(2);
         chk("state", 12'(dev_act), 12'(row[i][0]));
         chk("chan en", 12'({clk_en, den}), 12'({4{row[i][0]}}));
      end
   endtask : s_enable
   task automatic s_detect();
      logic [11:0] up[4] = '{12'h046, 12'h037, 12'h05A, 12'h04B};
      logic [11:0] lo[4] = '{12'h028, 12'h01E, 12'h037, 12'h02D};
      for (int c = 0; c < 4; c++)
      begin
         w(8'h05, {6'h00, c[1:0]});
         w(8'h06, {6'h00, c[1:0]});
         chk("codes", 12'({up_c, lo_c}), 12'({2{c[1:0]}}));
         // Equal to a level is not a crossing, so the flag must hold
         for (int k = 0; k < 5; k++)
         begin
            amp = k == 0 ? 12'h000 : k < 3 ? 12'(up[c] + k - 1) :
               12'(lo[c] + 3 - k);
            tick(2);
            chk("detect", 12'(det), 12'(k == 2 || k == 3));
            if (k == 2)
               rchk("status", 8'h00, 8'h01);
         end
      end
   endtask : s_detect
   task automatic s_level();
      for (int c = 0; c < 4; c++)
      begin
         w(8'h08, {4'h7, c[1:0], 2'h0});
         tick(2);
         chk("level", 12'(lvl), 12'(c[1:0]));
      end
   endtask : s_level
   task automatic s_auto();
      w(8'h07, 8'h00);
      boost_src = 1'h1;
      auto_en = 1'h1;
      amp = 12'h100;
      wait_for(1'h1);
      chk("auto on", 12'({clk_en, den}), 12'h00F);
      amp = 12'h000;
      wait_for(1'h0);
      chk("auto off", 12'({clk_en, den}), 12'h000);
   endtask : s_auto
   ////////////////////////////////////////
   initial
   begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   initial
   begin
      failures = 0;
      compares = 0;
      nrst = 1'h0;
      boost_src = 1'h1;
      boost_pins = 3'h0;
      en_pin = 1'h0;
      auto_en = 1'h0;
      amp = 12'h000;
      tick(2);
      nrst = 1'h1;
      tick(1);
      s_reset();
      s_boost();
      s_enable();
      s_detect();
      s_level();
      s_auto();
      print_verdict();
   end
endmodule : tb
